// *** hdl/sdf_cfg.svh ***
// Constants of the sigma-delta decimation filter
// Assumes inclusion by bare name from the design files
`ifndef SDF_CFG_SVH
`define SDF_CFG_SVH
// ----------------------------------------
// Ratio selection
// ----------------------------------------
`define SDF_RATIO_BASE_LOG2    7
`define SDF_SINC3_MAX_LOG2     10
`define SDF_SEL_CASCADE        3'h4
`define SDF_FAST_CONVERSIONS   2'h2
// ----------------------------------------
// Settling times in master clock cycles, then master clocks per modulator bit
// ----------------------------------------
`define SDF_SETTLE_128         856
`define SDF_SETTLE_256         1112
`define SDF_SETTLE_512         1624
`define SDF_SETTLE_1024        2648
`define SDF_SETTLE_2048        4696
`define SDF_SETTLE_4096        8792
`define SDF_SETTLE_8192        16984
`define SDF_SETTLE_16384       33368
`define SDF_MCLK_PER_MOD       2
`endif

// *** hdl/sdf_channel.sv ***
// One channel: sinc3 path, fast sinc1 path and cascaded sinc1 stage
// Assumes strobes from sdf_rate_div; bitstream valid on mod_tick
`default_nettype none
`include "sdf_cfg.svh"
module sdf_channel
	import sdf_pkg::*;
#(
	parameter int ACC_W = 48
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic             restart,
	input  wire logic             mod_tick,
	input  wire logic             sinc3_dump,
	input  wire logic             out_dump,
	input  wire logic             cascade,
	input  wire logic             mod_bit,
	output logic                  sample_strobe,
	output logic [ACC_W-1:0]      sample
);
	logic [ACC_W-1:0] i1, i2, i3, d1, d2, c1, c2, s3, s1_acc, fast_acc, s1_sum;
	logic [ACC_W-1:0] x;
	logic [ACC_W-1:0] i3_next;
	logic [1:0]       conv_cnt;
	sdf_path_t        path;

	// ----------------------------------------
	// Sinc3 integrators and combs
	// ----------------------------------------
	assign x      = mod_bit ? ACC_W'(1) : '0;
	assign s1_sum = s1_acc + s3;
	assign i3_next = i3 + i2;
	assign path   = (conv_cnt < `SDF_FAST_CONVERSIONS) ? SDF_PATH_FAST : SDF_PATH_SINC3;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{i1, i2, i3, d1, d2, s3, c1, c2} <= '0;
			{s1_acc, fast_acc, sample}       <= '0;
			conv_cnt      <= '0;
			sample_strobe <= 1'b0;
		end else if (restart) begin
			{i1, i2, i3, d1, d2, s3, c1, c2} <= '0;
			{s1_acc, fast_acc}               <= '0;
			sample_strobe <= 1'b0;
		end else begin
			sample_strobe <= 1'b0;
			if (mod_tick) begin
				i1 <= i1 + x;
				i2 <= i2 + i1;
				i3 <= i3 + i2;
				fast_acc <= out_dump ? '0 : fast_acc + x;
			end
			if (sinc3_dump) begin
				d1 <= i3_next;
				c1 <= i3_next - d1;
				d2 <= c1;
				c2 <= c1 - d2;
				s3 <= (c1 - d2) - c2;
			end
			if (out_dump) begin
				s1_acc <= '0;
				sample_strobe <= 1'b1;
				if (path == SDF_PATH_FAST)
					sample <= fast_acc + x;
				else if (cascade)
					sample <= s1_sum;
				else
					sample <= (c1 - d2) - c2;
				if (path == SDF_PATH_FAST)
					conv_cnt <= conv_cnt + 1'b1;
			end else if (sinc3_dump && cascade) begin
				s1_acc <= s1_sum;
			end
		end
	end
endmodule : sdf_channel
`default_nettype wire

// *** hdl/sdf_pkg.sv ***
// Types of the sigma-delta decimation filter
// Assumes the constants header sdf_cfg.svh
`default_nettype none
package sdf_pkg;
	typedef enum logic [1:0] {
		SDF_PATH_FAST,
		SDF_PATH_SINC3
	} sdf_path_t;
endpackage : sdf_pkg
`default_nettype wire

// *** hdl/sdf_rate_div.sv ***
// Modulator-rate and decimation strobe generator
// Assumes a free-running master clock; restart resynchronises all channels
`default_nettype none
`include "sdf_cfg.svh"
module sdf_rate_div
	import sdf_pkg::*;
#(
	parameter int CNT_W = 14
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic             restart,
	input  wire logic [2:0]       ratio_select,
	output logic                  mod_tick,
	output logic                  sinc3_dump,
	output logic                  out_dump
);
	logic             half;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] s3_mask;
	logic [CNT_W-1:0] all_mask;
	logic [2:0]       s3_sel;

	// ----------------------------------------
	// Ratio masks
	// ----------------------------------------
	assign s3_sel   = (ratio_select >= `SDF_SEL_CASCADE) ? 3'h3 : ratio_select;
	assign s3_mask  = CNT_W'((32'h0000_0001 << (`SDF_RATIO_BASE_LOG2 + s3_sel)) - 1);
	assign all_mask = CNT_W'((32'h0000_0001 << (`SDF_RATIO_BASE_LOG2 + ratio_select)) - 1);
	assign mod_tick   = half;
	assign sinc3_dump = half && ((cnt & s3_mask) == s3_mask);
	assign out_dump   = half && ((cnt & all_mask) == all_mask);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			half <= 1'b0;
			cnt  <= '0;
		end else if (restart) begin
			half <= 1'b0;
			cnt  <= '0;
		end else begin
			half <= ~half;
			if (half)
				cnt <= cnt + 1'b1;
		end
	end
endmodule : sdf_rate_div
`default_nettype wire

// *** hdl/sdf_top.sv ***
// Multi-channel sigma-delta decimation filter
// Assumes one modulator bit per channel, sampled on the modulator-rate enable
`default_nettype none
`include "sdf_cfg.svh"
module sdf_top
	import sdf_pkg::*;
#(
	parameter int CHANNELS = 6,
	parameter int ACC_W    = 48,
	parameter int SET_W    = 16
) (
	input  wire logic                      clock,
	input  wire logic                      arst_n,
	input  wire logic [2:0]                ratio_select,
	input  wire logic                      resync,
	input  wire logic [CHANNELS-1:0]       channel_restart,
	input  wire logic [CHANNELS-1:0]       mod_bits,
	output logic                           sample_ready_n,
	output logic [CHANNELS*ACC_W-1:0]      samples,
	output logic [SET_W-1:0]               settle_cycles
);
	logic                mod_tick;
	logic                sinc3_dump;
	logic                out_dump;
	logic                cascade;
	logic [2:0]          ratio_q;
	logic                ratio_chg;
	logic                global_restart;
	logic [CHANNELS-1:0] strobes;
	logic [SET_W-1:0]    next_settle;

	// ----------------------------------------
	// Ratio change acts as resynchronisation
	// ----------------------------------------
	assign ratio_chg      = (ratio_select != ratio_q);
	assign global_restart = resync | ratio_chg;
	assign cascade        = (ratio_select >= `SDF_SEL_CASCADE);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			ratio_q <= '0;
		else
			ratio_q <= ratio_select;
	end

	// ----------------------------------------
	// Settling time lookup for the host
	// ----------------------------------------
	always_comb begin
		case (ratio_select)
			3'h0:    next_settle = SET_W'(`SDF_SETTLE_128);
			3'h1:    next_settle = SET_W'(`SDF_SETTLE_256);
			3'h2:    next_settle = SET_W'(`SDF_SETTLE_512);
			3'h3:    next_settle = SET_W'(`SDF_SETTLE_1024);
			3'h4:    next_settle = SET_W'(`SDF_SETTLE_2048);
			3'h5:    next_settle = SET_W'(`SDF_SETTLE_4096);
			3'h6:    next_settle = SET_W'(`SDF_SETTLE_8192);
			default: next_settle = SET_W'(`SDF_SETTLE_16384);
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			settle_cycles <= '0;
		else
			settle_cycles <= next_settle;
	end

	// ----------------------------------------
	// Common timing base
	// ----------------------------------------
	sdf_rate_div u_div (
		.clock        (clock),
		.arst_n       (arst_n),
		.restart      (global_restart),
		.ratio_select (ratio_select),
		.mod_tick     (mod_tick),
		.sinc3_dump   (sinc3_dump),
		.out_dump     (out_dump)
	);

	// ----------------------------------------
	// Per-channel filters
	// ----------------------------------------
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
		sdf_channel #(.ACC_W(ACC_W)) u_ch (
			.clock         (clock),
			.arst_n        (arst_n),
			.restart       (global_restart | channel_restart[ch]),
			.mod_tick      (mod_tick),
			.sinc3_dump    (sinc3_dump),
			.out_dump      (out_dump),
			.cascade       (cascade),
			.mod_bit       (mod_bits[ch]),
			.sample_strobe (strobes[ch]),
			.sample        (samples[ch*ACC_W +: ACC_W])
		);
	end

	// ----------------------------------------
	// Data ready, active low one cycle per result
	// ----------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			sample_ready_n <= 1'b1;
		else
			sample_ready_n <= ~(out_dump & ~global_restart);
	end
	logic unused_strobes;
	assign unused_strobes = ^strobes;
endmodule : sdf_top
`default_nettype wire

// *** tb/sdf_mod_model.sv ***
// Modulator stand-in driving fixed-density bitstreams
// Assumes the filter's master clock and reset
`default_nettype none
module sdf_mod_model #(
	parameter int CHANNELS = 6
) (
	input  wire logic                clock,
	input  wire logic                arst_n,
	output logic [CHANNELS-1:0]      mod_bits
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase;
	// ----------------------------------------
	// Pattern steps once per two clocks
	// ----------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end
	// Channel 0 ones, channel 1 zeros, rest alternate
	assign mod_bits = {{(CHANNELS-2){phase[1]}}, 1'b0, 1'b1};
endmodule : sdf_mod_model
`default_nettype wire

// *** tb/sdf_top_checker.sv ***
// Assertions on the ports of sdf_top
// Assumes bind onto every sdf_top instance
`default_nettype none
module sdf_top_checker #(
	parameter int CHANNELS = 6,
	parameter int ACC_W    = 48,
	parameter int SET_W    = 16
) (
	input wire logic                      clock,
	input wire logic                      arst_n,
	input wire logic [2:0]                ratio_select,
	input wire logic                      resync,
	input wire logic [CHANNELS-1:0]       channel_restart,
	input wire logic [CHANNELS-1:0]       mod_bits,
	input wire logic                      sample_ready_n,
	input wire logic [CHANNELS*ACC_W-1:0] samples,
	input wire logic [SET_W-1:0]          settle_cycles
);
	timeunit 1ns;
	timeprecision 1ns;
	int         per;
	int         gap;
	int         age;
	logic       seen;
	logic       fresh;
	logic [2:0] last;
	logic       brk;
	logic [SET_W-1:0] exp_set;
	assign per = 256 << ratio_select;
	assign exp_set = SET_W'(600 + per);
	assign brk = resync || (ratio_select != last);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gap <= 0;
			age <= 0;
			seen <= 1'b0;
			fresh <= 1'b1;
			last <= 3'h0;
		end else begin
			last <= ratio_select;
			age <= age + 1;
			gap <= (!sample_ready_n || brk) ? 0 : gap + 1;
			seen <= brk ? 1'b0 : (seen | !sample_ready_n);
			fresh <= fresh & !brk;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	chk_ready_one: assert property (!sample_ready_n |=> sample_ready_n)
		else $error("ready held low");
	chk_ready_spaced: assert property (!sample_ready_n |=> sample_ready_n [*8])
		else $error("results too close");
	chk_settle_val: assert property ($stable(ratio_select) && $past(arst_n) |-> settle_cycles == exp_set)
		else $error("settling time wrong");
	chk_settle_follow: assert property ($changed(ratio_select) |=> ##[0:1] settle_cycles == exp_set)
		else $error("settling time not updated");
	chk_samples_hold: assert property (sample_ready_n |-> $stable(samples))
		else $error("samples moved without ready");
	chk_result_period: assert property (!sample_ready_n && seen |-> gap == per - 1)
		else $error("result spacing wrong");
	chk_gap_bound: assert property (gap <= per)
		else $error("result missing");
	chk_first_result: assert property (!sample_ready_n && fresh && !seen |-> age == per)
		else $error("first result late or early");
endmodule : sdf_top_checker
bind sdf_top sdf_top_checker #(.CHANNELS(CHANNELS), .ACC_W(ACC_W), .SET_W(SET_W)) u_chk (.clock, .arst_n,
	.ratio_select, .resync, .channel_restart, .mod_bits, .sample_ready_n, .samples, .settle_cycles);
`default_nettype wire

// *** tb/test_sigma_delta_decimation_filter.sv ***
// Self-checking bench for sdf_top
// Assumes sdf_mod_model as modulator and the bound checker
`default_nettype none
module test_sigma_delta_decimation_filter;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clock = 1'b0;
	logic         arst_n = 1'b0;
	logic [2:0]   ratio_select = 3'h0;
	logic         resync = 1'b0;
	logic [5:0]   channel_restart = 6'h00;
	wire logic [5:0]   mod_bits;
	wire logic         sample_ready_n;
	wire logic [287:0] samples;
	wire logic [15:0]  settle_cycles;
	int mismatches = 0;
	int n_checks = 0;
	always #4 clock = ~clock;
	sdf_mod_model #(.CHANNELS(6)) u_mod (.clock, .arst_n, .mod_bits);
	sdf_top DUT (.clock, .arst_n, .ratio_select, .resync, .channel_restart, .mod_bits,
		.sample_ready_n, .samples, .settle_cycles);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : cmp
	function automatic logic [47:0] ch(input int c);
		return samples[c*48 +: 48];
	endfunction : ch
	task automatic do_reset(input logic [2:0] code);
		@(posedge clock);
		ratio_select <= code;
		arst_n <= 1'b0;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
	endtask : do_reset
	task automatic wait_ready(output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (sample_ready_n !== 1'b0 && n < 40000);
		if (n >= 40000)
			cmp(48'h0, 48'h1);
	endtask : wait_ready
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_fast;
		int n;
		do_reset(3'h0);
		wait_ready(n);
		cmp(ch(0), 48'h0080);
		cmp(ch(1), 48'h0000);
		cmp(ch(5), 48'h0040);
		wait_ready(n);
		cmp(48'(n), 48'h0100);
		cmp(ch(0), 48'h0080);
		wait_ready(n);
		wait_ready(n);
		cmp(ch(0), 48'h0020_0000);
		cmp(ch(2), 48'h0010_0000);
		cmp(48'(settle_cycles), 48'h0358);
		@(posedge clock);
		channel_restart <= 6'h04;
		@(posedge clock);
		channel_restart <= 6'h00;
		wait_ready(n);
		cmp(ch(0), 48'h0020_0000);
		cmp(48'(ch(2) !== 48'h0010_0000), 48'h1);
		$display("t_fast done");
	endtask : t_fast
	task automatic t_ratios;
		int n;
		for (int c = 0; c < 8; c++) begin
			@(posedge clock);
			ratio_select <= 3'(c);
			if (c < 6) begin
				wait_ready(n);
				wait_ready(n);
				cmp(48'(n), 48'(256 << c));
			end else begin
				repeat (2) @(posedge clock);
				#1;
			end
			cmp(48'(settle_cycles), 48'(600 + (256 << c)));
		end
		@(posedge clock);
		ratio_select <= 3'h5;
		@(posedge clock);
		resync <= 1'b1;
		@(posedge clock);
		resync <= 1'b0;
		wait_ready(n);
		wait_ready(n);
		cmp(48'(n), 48'h2000);
		$display("t_ratios done");
	endtask : t_ratios
	task automatic t_cascade;
		int n;
		do_reset(3'h4);
		wait_ready(n);
		cmp(ch(0), 48'h0800);
		wait_ready(n);
		cmp(48'(n), 48'h1000);
		wait_ready(n);
		cmp(ch(0), 48'h8000_0000);
		cmp(ch(2), 48'h4000_0000);
		$display("t_cascade done");
	endtask : t_cascade
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	initial begin
		t_fast();
		t_ratios();
		t_cascade();
		conclude();
	end
	initial begin
		repeat (80000) @(posedge clock);
		mismatches++;
		conclude();
	end
endmodule : test_sigma_delta_decimation_filter
`default_nettype wire
